// *** bench/host_side_model.sv ***
/* Host and board model driving the shared pins and the event line.
   Assumes the bench steers it; detached pins sit on their pull-ups. */
`timescale 1ns/100ps
module host_side_model (
  input wire logic clk_sys,
  input wire logic attach,
  input wire logic aidOn,
  input wire logic [3:0] level,
  output logic rxIn,
  output logic dataIn,
  output logic clockIn,
  output logic ext_event_in
);
  // 250 cycles a phase: 500 kHz, far longer than the shortest legal phase
  logic [7:0] aidCnt = 8'h00;
  logic aidWave = 1'b0;
  always_ff @(posedge clk_sys) begin
    aidCnt <= (aidCnt == 8'hF9) ? 8'h00 : aidCnt + 8'h01;
    if (aidCnt == 8'hF9) aidWave <= !aidWave;
  end
  // detached lines rest on their pull-ups; nothing here ever pulls a strap pin low
  assign {clockIn, dataIn, rxIn} = attach ? level[2:0] : 3'h7;
  assign ext_event_in = !attach ? 1'b1 : (aidOn ? aidWave : level[3]);
endmodule

// *** bench/pin_control_checker.sv ***
/* Port checker for the pin control block.
   Assumes it is bound to gnss_module_pin_control and sees only its ports. */
`timescale 1ns/100ps
module pin_control_checker
  import pin_control_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic rxIn,
  input wire logic dataIn,
  input wire logic clockIn,
  input wire logic [LEVEL_W-1:0] bufferedBytes,
  input wire pending_cfg_t pendingCfg,
  input wire event_mode_t eventMode,
  input wire logic eventActiveHigh,
  input wire logic ext_event_in,
  input wire logic spiMode,
  input wire logic uartRx,
  input wire logic spiMosi,
  input wire logic spiCs_n,
  input wire logic spiClk,
  input wire logic transmitPending,
  input wire logic receiverOn,
  input wire logic timeSync,
  input wire logic timePulseOut,
  input wire logic amp_power_ctl,
  input wire logic [COUNT_W-1:0] rtcTime
);
  // the internal reset copy and the strap take a few edges to settle
  logic [2:0] up;
  logic live;
  assign live = (up == 3'h7);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) up <= 3'h0;
    else if (!live) up <= up + 3'h1;
  end
  function automatic logic pendExp(logic [LEVEL_W-1:0] n, pending_cfg_t c);
    return c.pendingActiveHigh ~^ (n != 16'h0000 && n >= c.byteThreshold);
  endfunction
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!live);
  sequence syncEdge;
    eventMode == EV_TIME && eventActiveHigh && $rose(ext_event_in);
  endsequence
  sequence syncAnswer;
    timeSync ##1 (!timeSync && timePulseOut);
  endsequence
  ////////////////////////////////////////////////////////////
  AST_STRAP_HELD: assert property ($stable(spiMode))
    else $error("interface mode moved");
  AST_SPI_MAP: assert property (spiMode |-> spiMosi == $past(rxIn) &&
    spiCs_n == $past(dataIn) && spiClk == $past(clockIn)) else $error("spi mapping");
  AST_UART_MAP: assert property (!spiMode |-> uartRx == $past(rxIn) && spiCs_n)
    else $error("uart mapping");
  AST_PENDING: assert property ($past(pendingCfg) == pendingCfg &&
    $past(pendingCfg, 2) == pendingCfg |->
    transmitPending == pendExp($past(bufferedBytes, 2), pendingCfg)) else $error("pending");
  AST_POWER: assert property (eventMode == EV_POWER && $past(eventMode) == EV_POWER
    && eventActiveHigh |-> receiverOn == $past(ext_event_in)) else $error("power");
  AST_AMP: assert property ($stable(receiverOn) |-> amp_power_ctl == receiverOn)
    else $error("amplifier");
  AST_TIME_SYNC: assert property (syncEdge |=> syncAnswer)
    else $error("time sync");
  AST_EV_OFF: assert property (eventMode == EV_OFF |=> !timeSync)
    else $error("event while off");
  AST_RTC_CLEAR: assert property (@(posedge clk_sys) disable iff (1'b0)
    !reset_n && $past(!reset_n) |-> rtcTime == RTC_RESET) else $error("rtc in reset");
endmodule
bind gnss_module_pin_control pin_control_checker chk_u (.clk_sys, .reset_n, .rxIn,
  .dataIn, .clockIn, .bufferedBytes, .pendingCfg, .eventMode, .eventActiveHigh,
  .ext_event_in, .spiMode, .uartRx, .spiMosi, .spiCs_n, .spiClk, .transmitPending,
  .receiverOn, .timeSync, .timePulseOut, .amp_power_ctl, .rtcTime);

// *** bench/tb.sv ***
/* Self-checking bench for the pin control block with random pin traffic.
   Assumes the checker is bound to the design and the host model drives pins. */
`timescale 1ns/100ps
module tb
  import pin_control_pkg::*;
;
  localparam logic [COUNT_W-1:0] SIM_PERIOD = 32'h00000014;
  localparam logic [COUNT_W-1:0] SIM_WIDTH = 32'h00000005;
  logic clk_sys, reset_n, interfaceSelect, attach, aidOn, eventActiveHigh;
  logic uartTx, spiMiso, i2cDataOut, i2cDataDrive, powerSaveOn;
  logic [3:0] level;
  logic [LEVEL_W-1:0] bufferedBytes;
  pending_cfg_t pendingCfg;
  event_mode_t eventMode;
  logic [COUNT_W-1:0] rtcTime;
  logic rxIn, dataIn, clockIn, ext_event_in, spiMode, txPinOut, txPinOe_n;
  logic dataPinOut, dataPinOe_n, eventPinOut, eventPinOe_n, uartRx, spiMosi;
  logic spiCs_n, spiClk, i2cDataIn, i2cClk, transmitPending, wakeRequest;
  logic receiverOn, timeSync, freqEdge, freqPhaseShort, timePulseOut, amp_power_ctl;
  logic [31:0] rnd;
  logic [6:0] p;
  logic [59:0] trace;
  int err_total, checked, ne;
  gnss_module_pin_control #(.PULSE_PERIOD(SIM_PERIOD), .PULSE_WIDTH(SIM_WIDTH)) dut_u (
    .clk_sys, .reset_n, .interfaceSelect, .rxIn, .dataIn, .clockIn, .uartTx, .spiMiso,
    .i2cDataOut, .i2cDataDrive, .bufferedBytes, .pendingCfg, .eventMode, .eventActiveHigh,
    .ext_event_in, .powerSaveOn, .cycleActive(1'b1), .pulsePeriod(SIM_PERIOD),
    .pulseWidth(SIM_WIDTH), .pulseConfigured(1'b0), .spiMode, .txPinOut, .txPinOe_n,
    .dataPinOut, .dataPinOe_n, .eventPinOut, .eventPinOe_n, .uartRx, .spiMosi, .spiCs_n,
    .spiClk, .i2cDataIn, .i2cClk, .transmitPending, .wakeRequest, .receiverOn, .timeSync,
    .freqEdge, .freqPhaseShort, .timePulseOut, .amp_power_ctl, .rtcTime);
  host_side_model host_u (.clk_sys, .attach, .aidOn, .level, .rxIn, .dataIn, .clockIn,
    .ext_event_in);
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic pendExp(logic [LEVEL_W-1:0] n, pending_cfg_t c);
    return c.pendingActiveHigh ~^ (n != 16'h0000 && n >= c.byteThreshold);
  endfunction
  task automatic check(logic ok, string what);
    checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  task automatic complete_run;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset(logic sel);
    reset_n <= 1'b0;
    interfaceSelect <= sel;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys) check(rtcTime === RTC_RESET, "rtc not cleared");
    @(posedge clk_sys) reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = !clk_sys;
  end
  initial begin
    #16000;
    err_total++;
    $display("Error at %0t: timeout", $time);
    complete_run;
  end
  initial begin
    {reset_n, interfaceSelect, attach, aidOn, uartTx, spiMiso, powerSaveOn} = 7'h00;
    {i2cDataOut, i2cDataDrive, level, bufferedBytes, pendingCfg} = '0;
    {eventActiveHigh, eventMode, rnd} = {1'b1, EV_OFF, 32'h7CDD79B6};
    for (int s = 0; s < 2; s++) begin
      do_reset(s[0]);
      interfaceSelect <= !s[0];
      attach <= 1'b1;
      @(negedge clk_sys) p = {i2cDataDrive, i2cDataOut, uartTx, spiMiso, clockIn, dataIn, rxIn};
      repeat (40) begin
        @(posedge clk_sys) rnd = lfsr(rnd);
        {i2cDataDrive, i2cDataOut, uartTx, spiMiso, level} <= rnd[7:0];
        @(negedge clk_sys);
        if (s == 0) check({spiMosi, spiCs_n, spiClk, txPinOut} === {p[0], p[1], p[2], p[3]}, "spi pins");
        else check({uartRx, spiCs_n, txPinOut, txPinOe_n} === {p[0], 1'b1, p[4], 1'b0}, "uart");
        if (s == 0) check({dataPinOe_n, i2cDataIn, i2cClk} === 3'h7, "spi data pin");
        else check({dataPinOe_n, i2cDataIn, i2cClk} === {!(p[6] && !p[5]), p[1], p[2]}, "i2c");
        p = {i2cDataDrive, i2cDataOut, uartTx, spiMiso, clockIn, dataIn, rxIn};
      end
      check(spiMode === !s[0], "mode");
      $display("interface test %0d done", s);
    end
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys) rnd = lfsr(rnd);
      bufferedBytes <= (i == 0) ? 16'h0000 : {12'h000, rnd[3:0]};
      pendingCfg.byteThreshold <= (i == 0) ? 16'h0000 : {12'h000, rnd[7:4]};
      pendingCfg.pendingActiveHigh <= rnd[31];
      pendingCfg.onTransmitPin <= rnd[30];
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys) check(transmitPending === pendExp(bufferedBytes, pendingCfg), "pend");
      if (pendingCfg.onTransmitPin) check(txPinOut === pendExp(bufferedBytes, pendingCfg), "tx pend");
    end
    $display("pending test done");
    for (int m = 0; m < 5; m++) begin
      @(posedge clk_sys) eventMode <= event_mode_t'(m);
      {aidOn, powerSaveOn, level[3]} <= {m == 4, m == 1, 1'b0};
      repeat (4) @(posedge clk_sys);
      level[3] <= 1'b1;
      if (m == 2) check({receiverOn, amp_power_ctl} === 2'b00, "forced off");
      repeat (2) @(negedge clk_sys);
      check({timeSync, wakeRequest} === {m == 3, m == 1}, "event pulse");
      @(negedge clk_sys);
      if (m == 3) check(timePulseOut === 1'b1, "realign");
      if (m == 2) check({receiverOn, amp_power_ctl} === 2'b11, "override on");
      ne = 0;
      repeat ((m == 4) ? 500 : 0) @(negedge clk_sys) ne += freqEdge + 2 * freqPhaseShort;
      if (m == 4) check(ne inside {[1:3]} && ne % 2 == 1, "freq aid");
    end
    $display("event test done");
    @(posedge clk_sys) eventMode <= EV_OFF;
    for (int i = 0; i < 60; i++) @(negedge clk_sys) trace[i] = timePulseOut;
    check(trace[39:0] === trace[59:20] && $countones(trace[39:0]) == 10, "pulse");
    $display("time pulse test done");
    complete_run;
  end
endmodule

// *** verilog/gnss_module_pin_control.sv ***
/*
  Pin control of a positioning receiver: interface select strap, shared pin
  mapping, transmit pending, event input functions, time pulse, amplifier
  enable and the real-time clock counter reset.
  Assumes all inputs are synchronous to clk_sys; pin pull-ups live outside.
*/
`timescale 1ns/100ps
module gnss_module_pin_control
  import pin_control_pkg::*;
#(
  parameter logic [COUNT_W-1:0] PULSE_PERIOD = PULSE_PERIOD_DEF,
  parameter logic [COUNT_W-1:0] PULSE_WIDTH = PULSE_WIDTH_DEF
)(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic interfaceSelect,
  input wire logic rxIn,
  input wire logic dataIn,
  input wire logic clockIn,
  input wire logic uartTx,
  input wire logic spiMiso,
  input wire logic i2cDataOut,
  input wire logic i2cDataDrive,
  input wire logic [LEVEL_W-1:0] bufferedBytes,
  input wire pending_cfg_t pendingCfg,
  input wire event_mode_t eventMode,
  input wire logic eventActiveHigh,
  input wire logic ext_event_in,
  input wire logic powerSaveOn,
  input wire logic cycleActive,
  input wire logic [COUNT_W-1:0] pulsePeriod,
  input wire logic [COUNT_W-1:0] pulseWidth,
  input wire logic pulseConfigured,
  output logic spiMode,
  output logic txPinOut,
  output logic txPinOe_n,
  output logic dataPinOut,
  output logic dataPinOe_n,
  output logic eventPinOut,
  output logic eventPinOe_n,
  output logic uartRx,
  output logic spiMosi,
  output logic spiCs_n,
  output logic spiClk,
  output logic i2cDataIn,
  output logic i2cClk,
  output logic transmitPending,
  output logic wakeRequest,
  output logic receiverOn,
  output logic timeSync,
  output logic freqEdge,
  output logic freqPhaseShort,
  output logic timePulseOut,
  output logic amp_power_ctl,
  output logic [COUNT_W-1:0] rtcTime
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and strap capture

  logic rstMeta_n;
  logic rstSync_n;
  logic strapTaken;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // strap is caught by a clocked process after release, never by the reset itself
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      strapTaken <= 1'b0;
      spiMode <= 1'b0;
    end else if (!strapTaken) begin
      strapTaken <= 1'b1;
      spiMode <= ~interfaceSelect;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit pending

  logic pendingRaw;
  logic pendingPin;

  pending_flag pendingFlag (
    .clk_sys(clk_sys),
    .rstSync_n(rstSync_n),
    .bufferedBytes(bufferedBytes),
    .cfg(pendingCfg),
    .pendingRaw(pendingRaw),
    .pendingPin(pendingPin)
  );

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      transmitPending <= 1'b0;
    end else begin
      transmitPending <= pendingPin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared pin mapping

  logic pendingOnTx;
  logic pendingOnEvent;

  assign pendingOnTx = pendingCfg.onTransmitPin;
  // the event pin can only carry pending while no event function uses it
  assign pendingOnEvent = pendingCfg.onEventPin && (eventMode == EV_OFF);

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      txPinOut <= 1'b1;
      txPinOe_n <= 1'b1;
      dataPinOut <= 1'b1;
      dataPinOe_n <= 1'b1;
      eventPinOut <= 1'b1;
      eventPinOe_n <= 1'b1;
    end else begin
      if (pendingOnTx) begin
        txPinOut <= pendingPin;
      end else begin
        txPinOut <= spiMode ? spiMiso : uartTx;
      end
      txPinOe_n <= 1'b0;
      // chip select is an input in SPI mode; only I2C drives the data pin
      dataPinOut <= 1'b0;
      dataPinOe_n <= spiMode ? 1'b1 : ~(i2cDataDrive && !i2cDataOut);
      eventPinOut <= pendingPin;
      eventPinOe_n <= ~pendingOnEvent;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      uartRx <= 1'b1;
      spiMosi <= 1'b0;
      spiCs_n <= 1'b1;
      spiClk <= 1'b0;
      i2cDataIn <= 1'b1;
      i2cClk <= 1'b1;
    end else begin
      uartRx <= spiMode ? 1'b1 : rxIn;
      spiMosi <= spiMode ? rxIn : 1'b0;
      spiCs_n <= spiMode ? dataIn : 1'b1;
      spiClk <= spiMode ? clockIn : 1'b0;
      i2cDataIn <= spiMode ? 1'b1 : dataIn;
      i2cClk <= spiMode ? 1'b1 : clockIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event input functions

  logic eventLevel;
  logic eventPrev;
  logic eventRise;
  logic [7:0] phaseCount;

  assign eventLevel = (eventActiveHigh ? ext_event_in : ~ext_event_in) && !pendingOnEvent;
  assign eventRise = eventLevel && !eventPrev;

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      eventPrev <= 1'b0;
    end else begin
      eventPrev <= eventLevel;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wakeRequest <= 1'b0;
      timeSync <= 1'b0;
      freqEdge <= 1'b0;
    end else begin
      wakeRequest <= (eventMode == EV_WAKE) && powerSaveOn && eventRise;
      timeSync <= (eventMode == EV_TIME) && eventRise;
      freqEdge <= (eventMode == EV_FREQ) && eventRise;
    end
  end

  // flags a phase shorter than the host may legally send
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      phaseCount <= 8'h00;
      freqPhaseShort <= 1'b0;
    end else if (eventLevel != eventPrev) begin
      phaseCount <= 8'h01;
      freqPhaseShort <= (eventMode == EV_FREQ) &&
        (phaseCount < 8'(AID_MIN_PHASE_CYC));
    end else begin
      if (phaseCount != 8'hFF) begin
        phaseCount <= phaseCount + 8'h01;
      end
      freqPhaseShort <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      receiverOn <= 1'b1;
    end else if (eventMode == EV_POWER) begin
      receiverOn <= eventLevel;
    end else begin
      receiverOn <= powerSaveOn ? cycleActive : 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      amp_power_ctl <= 1'b0;
    end else begin
      amp_power_ctl <= receiverOn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time pulse and real-time clock

  // the generator's own flop drives the pin, so a sync shows one cycle after timeSync
  time_pulse_gen timePulse (
    .clk_sys(clk_sys),
    .rstSync_n(rstSync_n),
    .period(pulseConfigured ? pulsePeriod : PULSE_PERIOD),
    .width(pulseConfigured ? pulseWidth : PULSE_WIDTH),
    .syncEvent(timeSync),
    .pulse(timePulseOut)
  );

  // reset clears the real-time clock counter to RTC_RESET; it then counts up every cycle
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rtcTime <= RTC_RESET;
    end else begin
      rtcTime <= rtcTime + 32'h00000001;
    end
  end

endmodule

// *** verilog/pending_flag.sv ***
/*
  Transmit pending indicator: compares buffered byte count with a threshold.
  Assumes the byte count comes from the output buffer on the same clock.
*/
`timescale 1ns/100ps
module pending_flag
  import pin_control_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstSync_n,
  input wire logic [LEVEL_W-1:0] bufferedBytes,
  input wire pending_cfg_t cfg,
  output logic pendingRaw,
  output logic pendingPin
);

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pendingRaw <= 1'b0;
    end else begin
      // a zero threshold still needs at least one byte
      pendingRaw <= (bufferedBytes != '0) && (bufferedBytes >= cfg.byteThreshold);
    end
  end

  assign pendingPin = cfg.pendingActiveHigh ? pendingRaw : ~pendingRaw;

endmodule

// *** verilog/pin_control_pkg.sv ***
/*
  Package for the positioning receiver pin control block: constants, types, modes.
  Assumes a single 250 MHz system clock and plain control ports (no register bus).
*/
package pin_control_pkg;

  localparam int CLK_MHZ = 250;
  localparam int PULSE_PERIOD_MS = 1000;
  localparam int PULSE_WIDTH_MS = 100;
  localparam int PULSE_PERIOD_DEF = PULSE_PERIOD_MS * CLK_MHZ * 1000;
  localparam int PULSE_WIDTH_DEF = PULSE_WIDTH_MS * CLK_MHZ * 1000;
  localparam int AID_MAX_KHZ = 500;
  localparam int AID_MIN_PHASE_NS = 50;
  localparam int AID_MIN_PHASE_CYC = (AID_MIN_PHASE_NS * CLK_MHZ + 999) / 1000;
  localparam int COUNT_W = 32;
  localparam int LEVEL_W = 16;
  localparam logic [LEVEL_W-1:0] THRESHOLD_RESET = 16'h0001;
  localparam logic [COUNT_W-1:0] RTC_RESET = 32'h00000000;

  typedef enum logic [2:0] {
    EV_OFF = 3'h0,
    EV_WAKE = 3'h1,
    EV_POWER = 3'h2,
    EV_TIME = 3'h3,
    EV_FREQ = 3'h4
  } event_mode_t;

  typedef struct packed {
    logic pendingActiveHigh;
    logic [LEVEL_W-1:0] byteThreshold;
    logic onTransmitPin;
    logic onEventPin;
  } pending_cfg_t;

  typedef struct packed {
    logic txOut;
    logic txOe_n;
    logic dataOut;
    logic dataOe_n;
  } shared_drive_t;

endpackage

// *** verilog/time_pulse_gen.sv ***
/*
  Time pulse generator with configurable period and width; realigns to an
  external sync event. Assumes period > width > 0.
*/
`timescale 1ns/100ps
module time_pulse_gen
  import pin_control_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstSync_n,
  input wire logic [COUNT_W-1:0] period,
  input wire logic [COUNT_W-1:0] width,
  input wire logic syncEvent,
  output logic pulse
);

  logic [COUNT_W-1:0] count;

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      count <= '0;
    end else if (syncEvent || count >= period - 32'h00000001) begin
      count <= '0;
    end else begin
      count <= count + 32'h00000001;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pulse <= 1'b0;
    end else begin
      pulse <= syncEvent || (count < width - 32'h00000001) || (count >= period - 32'h00000001);
    end
  end

endmodule
